// ---- dv/testbench.sv ----
`timescale 1ns/1ps
module testbench;
	localparam logic [3:0] a_ctl = wan_tp_pkg::addr_test_control;
	localparam logic [3:0] a_cnt = wan_tp_pkg::addr_prbs_error_count;
	localparam logic [3:0] a_pst = wan_tp_pkg::addr_prbs_checker_status;
	localparam logic [3:0] a_path = wan_tp_pkg::addr_path_parity;
	logic clock, resetn, wr, rd, flip, tx_bit, rx_bit;
	logic [3:0] addr;
	logic [15:0] wdata, rdata, got;
	int err_total, checks_done, cycles;
	wan_test_pattern_gen_check u_wan_test_pattern_gen_check (.clock(clock),
		.resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .tx_bit(tx_bit), .rx_bit(rx_bit));
	wan_line_partner u_wan_line_partner (.clock(clock), .resetn(resetn),
		.tx_bit(tx_bit), .flip(flip), .rx_bit(rx_bit));
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	always @(posedge clock) begin
		cycles++;
		if (cycles == 5000) begin
			err_total++;
			wrap_up();
		end
	end
	task automatic wrap_up();
		$display("errors %0d checks %0d", err_total, checks_done);
		if (err_total == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : wrap_up
	task automatic cmp16(input logic [15:0] g, input logic [15:0] e);
		checks_done++;
		if (g !== e) begin
			err_total++;
			$display("MISMATCH %0t got %h want %h", $time, g, e);
		end
	endtask : cmp16
	task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clock);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clock);
		wr <= 1'b0;
	endtask : reg_wr
	task automatic reg_rd(input logic [3:0] a);
		@(posedge clock);
		rd <= 1'b1;
		addr <= a;
		@(posedge clock);
		rd <= 1'b0;
		#1 got = rdata;
	endtask : reg_rd
	task automatic reg_chk(input logic [3:0] a, input logic [15:0] e);
		reg_rd(a);
		cmp16(got, e);
	endtask : reg_chk
	task automatic line_err(input int wait_cycles);
		@(posedge clock);
		flip <= 1'b1;
		@(posedge clock);
		flip <= 1'b0;
		repeat (wait_cycles) @(posedge clock);
	endtask : line_err
	initial begin
		{resetn, wr, rd, flip, addr, wdata} = '0;
		{err_total, checks_done, cycles} = '0;
		repeat (12) @(posedge clock);
		resetn <= 1'b1;
		repeat (3) @(posedge clock);
		reg_chk(wan_tp_pkg::addr_test_status, 16'h0001);
		reg_wr(4'hf, 16'hffff);
		reg_chk(4'hf, 16'h0000);
		// Square wave looped back, one line error must not count
		reg_wr(wan_tp_pkg::addr_tx_ext_control, 16'h0003);
		reg_wr(a_ctl, 16'h0007);
		line_err(60);
		reg_rd(a_path);
		reg_chk(a_path, 16'h0000);
		reg_wr(a_ctl, 16'h0006);
		repeat (60) @(posedge clock);
		reg_rd(a_path);
		reg_chk(a_path, 16'h0000);
		line_err(60);
		reg_rd(wan_tp_pkg::addr_section_parity);
		cmp16(got, 16'h0002);
		reg_rd(a_path);
		reg_wr(a_ctl, 16'h0002);
		line_err(60);
		reg_chk(a_path, 16'h0000);
		reg_wr(a_ctl, 16'h0018);
		repeat (100) @(posedge clock);
		reg_chk(a_cnt, 16'h0000);
		reg_chk(a_pst, 16'h0002);
		// Injected bit first, then a line error
		for (int i = 0; i < 2; i++) begin
			if (i == 0)
				reg_wr(wan_tp_pkg::addr_error_inject_control, 16'h0001);
			else
				line_err(0);
			repeat (80) @(posedge clock);
			reg_chk(a_pst, 16'h0003);
			reg_chk(a_cnt, 16'h0003);
			reg_chk(a_cnt, 16'h0000);
		end
		reg_wr(a_ctl, 16'h001a);
		repeat (120) @(posedge clock);
		reg_chk(a_pst, 16'h0001);
		reg_wr(a_ctl, 16'h0008);
		repeat (50) @(posedge clock);
		reg_rd(a_cnt);
		reg_chk(a_cnt, 16'h0000);
		reg_chk(a_pst, 16'h0000);
		wrap_up();
	end
endmodule : testbench

// ---- dv/wan_line_partner.sv ----
`timescale 1ns/1ps
// Far end looping the line back after a delay; flip corrupts one bit
module wan_line_partner #(parameter int delay = 2) (
	// Clock and reset
	input wire logic clock,
	input wire logic resetn,
	// Line
	input wire logic tx_bit,
	input wire logic flip,
	output logic rx_bit
);
	logic [delay-1:0] line_r;
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn)
			line_r <= '0;
		else
			line_r <= {line_r[delay-2:0], tx_bit};
	end
	assign rx_bit = line_r[delay-1] ^ flip;
endmodule : wan_line_partner

// ---- dv/wan_tp_monitor.sv ----
`timescale 1ns/1ps
module wan_tp_monitor (
	// Clock and reset
	input wire logic clock,
	input wire logic resetn,
	// Register port
	input wire logic [3:0] addr,
	input wire logic [15:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [15:0] rdata,
	// Serial line
	input wire logic tx_bit,
	input wire logic rx_bit
);
	logic [4:0] ctrl_r;
	logic [3:0] width_r;
	logic [5:0] quiet_r;
	wire sq_on = ctrl_r[1:0] == 2'h3;
	wire mix_on = ctrl_r[1:0] == 2'h2;
	wire prbs_on = ctrl_r[3:1] == 3'h4;
	wire settled = quiet_r > 6'h27;
	wire rd_cnt = rd && addr == wan_tp_pkg::addr_prbs_error_count;
	wire rd_path = rd && addr == wan_tp_pkg::addr_path_parity;
	wire rd_st = rd && addr == wan_tp_pkg::addr_prbs_checker_status;
	// Mode mirror; quiet_r masks transients after any write
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			ctrl_r <= 5'h00;
			width_r <= 4'h4;
			quiet_r <= 6'h00;
		end else begin
			if (wr && addr == wan_tp_pkg::addr_test_control)
				ctrl_r <= wdata[4:0];
			if (wr && addr == wan_tp_pkg::addr_tx_ext_control)
				width_r <= wdata[3:0];
			quiet_r <= wr ? 6'h00 : quiet_r + {5'h00, quiet_r != 6'h3f};
		end
	end
	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);
	chk_rdata_idle: assert property (
		!$past(rd) |-> rdata == 16'h0000) else $error("rdata set without read");
	chk_prbs_ability: assert property (
		$past(rd_st && 1'b0) || $past(rd) && $past(addr) ==
		wan_tp_pkg::addr_test_status |-> rdata[0]) else $error("ability low");
	chk_prbs_poly: assert property (
		prbs_on && settled |-> tx_bit == ($past(tx_bit, 28) ^ $past(tx_bit, 31)))
		else $error("prbs sequence broken");
	chk_square_run: assert property (
		sq_on && width_r == 4'h3 && quiet_r > 6'h0f |-> tx_bit != $past(tx_bit, 3))
		else $error("square run length wrong");
	chk_mixed_loop: assert property (
		mix_on && quiet_r > 6'h17 |-> tx_bit == $past(tx_bit, 16))
		else $error("mixed pattern not periodic");
	chk_count_clear: assert property (
		rd_cnt ##2 (rd_cnt && !ctrl_r[4] && settled) |=> rdata == 16'h0000)
		else $error("count not cleared by read");
	chk_status_idle: assert property (
		rd_cnt ##2 (rd_st && !ctrl_r[4] && settled) |=> rdata[1:0] == 2'h0)
		else $error("status set with checker off");
	chk_square_quiet: assert property (
		rd_path ##2 (rd_path && sq_on && settled) |=> rdata == 16'h0000)
		else $error("square traffic counted");
endmodule : wan_tp_monitor
bind wan_test_pattern_gen_check wan_tp_monitor u_wan_tp_monitor (.*);

// ---- rtl/sat_counter.sv ----
`timescale 1ns/1ps
// Saturating counter, cleared by read; an increment in the read cycle survives the clear
module sat_counter (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Control
	input wire logic [1:0] inc,
	input wire logic read_clear,
	// Value
	output logic [15:0] count
);
	logic [16:0] sum;
	logic [15:0] base;
	logic [15:0] count_nxt;

	assign base = read_clear ? 16'h0000 : count;
	assign sum = {1'b0, base} + {15'h0000, inc};
	assign count_nxt = sum[16] ? wan_tp_pkg::count_max : sum[15:0];

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			count <= 16'h0000;
		end else begin
			count <= count_nxt;
		end
	end
endmodule : sat_counter

// ---- rtl/wan_test_pattern_gen_check.sv ----
`timescale 1ns/1ps
module wan_test_pattern_gen_check (
	// Clock and reset
	input wire logic clock,
	input wire logic resetn,
	// Register port
	input wire logic [3:0] addr,
	input wire logic [15:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [15:0] rdata,
	// Serial line, one bit per clock
	output logic tx_bit,
	input wire logic rx_bit
);
	logic rst_a_r;
	logic rst_n_r;
	logic [15:0] ctrl_r;
	logic [3:0] width_r;
	logic inject_r;
	logic [15:0] rdata_r;
	logic tx_r;
	logic [30:0] gen_r;
	logic [30:0] chk_r;
	logic [3:0] sq_cnt_r;
	logic sq_level_r;
	logic [3:0] mix_idx_r;
	logic [4:0] good_r;
	logic locked_r;
	logic [2:0] bad_r;
	logic [15:0] mix_hist_r;
	logic [15:0] mix_err_r;

	// Reset release through two flops
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			rst_a_r <= 1'b0;
			rst_n_r <= 1'b0;
		end else begin
			rst_a_r <= 1'b1;
			rst_n_r <= rst_a_r;
		end
	end

	wire sel_sq = ctrl_r[wan_tp_pkg::bit_square_wave_select];
	wire pat_gen = ctrl_r[wan_tp_pkg::bit_pattern_gen_enable];
	wire pat_chk = ctrl_r[wan_tp_pkg::bit_pattern_check_enable];
	wire prbs_gen = ctrl_r[wan_tp_pkg::bit_prbs_gen_enable];
	wire prbs_chk = ctrl_r[wan_tp_pkg::bit_prbs_check_enable];

	// Pattern priority
	wire [1:0] mode = !pat_gen ? (prbs_gen ? wan_tp_pkg::pattern_prbs
		: wan_tp_pkg::pattern_idle)
		: (sel_sq ? wan_tp_pkg::pattern_square
		: wan_tp_pkg::pattern_mixed);

	// Decode
	wire wr_ctrl = wr && (addr == wan_tp_pkg::addr_test_control);
	wire wr_width = wr && (addr == wan_tp_pkg::addr_tx_ext_control);
	wire wr_inj = wr && (addr == wan_tp_pkg::addr_error_inject_control);
	wire rd_cnt = rd && (addr == wan_tp_pkg::addr_prbs_error_count);
	wire rd_mix = rd && (addr == wan_tp_pkg::addr_path_parity);

	// Generator LFSR, x^31 + x^28 + 1
	wire gen_fb = gen_r[wan_tp_pkg::prbs_len - 1]
		^ gen_r[wan_tp_pkg::prbs_tap - 1];
	wire do_inject = inject_r && (mode == wan_tp_pkg::pattern_prbs);

	// Square wave: width ones then width zeros
	wire [3:0] sq_lim = (width_r == 4'h0) ? 4'h1 : width_r;
	wire sq_wrap = (sq_cnt_r + 4'h1) >= sq_lim;

	wire mix_bit = wan_tp_pkg::mix_pattern[mix_idx_r];

	logic tx_nxt;
	always_comb begin
		case (mode)
			wan_tp_pkg::pattern_square: tx_nxt = sq_level_r;
			wan_tp_pkg::pattern_mixed: tx_nxt = mix_bit;
			wan_tp_pkg::pattern_prbs: tx_nxt = gen_fb ^ do_inject;
			default: tx_nxt = 1'b0;
		endcase
	end

	// Control register
	always_ff @(posedge clock or negedge rst_n_r) begin
		if (!rst_n_r) begin
			ctrl_r <= 16'h0000;
		end else if (wr_ctrl) begin
			ctrl_r <= wdata;
		end
	end

	// Square wave width
	always_ff @(posedge clock or negedge rst_n_r) begin
		if (!rst_n_r) begin
			width_r <= wan_tp_pkg::square_width_reset;
		end else if (wr_width) begin
			width_r <= wdata[wan_tp_pkg::square_width_bits - 1:0];
		end
	end

	// One-shot: cleared once the inverted bit has gone out
	always_ff @(posedge clock or negedge rst_n_r) begin
		if (!rst_n_r) begin
			inject_r <= 1'b0;
		end else if (wr_inj && wdata[wan_tp_pkg::bit_inject_bit_error]) begin
			inject_r <= 1'b1;
		end else if (do_inject) begin
			inject_r <= 1'b0;
		end
	end

	// Line output
	always_ff @(posedge clock or negedge rst_n_r) begin
		if (!rst_n_r) begin
			tx_r <= 1'b0;
		end else begin
			tx_r <= tx_nxt;
		end
	end

	// Injected bit never enters the register, so only one bit is wrong
	always_ff @(posedge clock or negedge rst_n_r) begin
		if (!rst_n_r) begin
			gen_r <= wan_tp_pkg::prbs_seed;
		end else if (mode == wan_tp_pkg::pattern_prbs) begin
			gen_r <= {gen_r[29:0], gen_fb};
		end
	end

	// Square wave phase
	always_ff @(posedge clock or negedge rst_n_r) begin
		if (!rst_n_r) begin
			sq_cnt_r <= 4'h0;
			sq_level_r <= 1'b1;
		end else if (mode == wan_tp_pkg::pattern_square) begin
			sq_cnt_r <= sq_wrap ? 4'h0 : sq_cnt_r + 4'h1;
			if (sq_wrap) begin
				sq_level_r <= ~sq_level_r;
			end
		end else begin
			sq_cnt_r <= 4'h0;
			sq_level_r <= 1'b1;
		end
	end

	// Mixed pattern index
	always_ff @(posedge clock or negedge rst_n_r) begin
		if (!rst_n_r) begin
			mix_idx_r <= 4'h0;
		end else begin
			mix_idx_r <= mix_idx_r + 4'h1;
		end
	end

	// Self-synchronizing checker: shift in received bits
	wire chk_pred = chk_r[wan_tp_pkg::prbs_len - 1]
		^ chk_r[wan_tp_pkg::prbs_tap - 1];
	wire chk_miss = prbs_chk && (chk_pred != rx_bit);
	// A received error is seen once here and again as it passes each tap
	wire tap_miss = prbs_chk && locked_r && chk_miss;
	logic [1:0] prbs_inc;
	assign prbs_inc = tap_miss ? 2'h1 : 2'h0;

	// One line error costs three misses; a fourth before a clean run
	// means the stream is no longer the one we locked to
	wire lock_run = good_r == wan_tp_pkg::lock_good_bits;
	wire lock_drop = locked_r && chk_miss
		&& (bad_r == wan_tp_pkg::lock_bad_limit);

	// Mixed pattern repeats every mix_len bits, so compare with the
	// bit received one period ago; no alignment to the far end needed
	wire mix_check = pat_chk && !sel_sq;
	wire mix_miss = mix_check
		&& (rx_bit != mix_hist_r[wan_tp_pkg::mix_len - 1]);

	// Checker history
	always_ff @(posedge clock or negedge rst_n_r) begin
		if (!rst_n_r) begin
			chk_r <= 31'h00000000;
		end else begin
			chk_r <= prbs_chk ? {chk_r[29:0], rx_bit} : 31'h00000000;
		end
	end

	// Run of correctly predicted bits
	always_ff @(posedge clock or negedge rst_n_r) begin
		if (!rst_n_r) begin
			good_r <= 5'h00;
		end else if (!prbs_chk || chk_miss) begin
			good_r <= 5'h00;
		end else if (!lock_run) begin
			good_r <= good_r + 5'h01;
		end
	end

	// Misses since the last clean run
	always_ff @(posedge clock or negedge rst_n_r) begin
		if (!rst_n_r) begin
			bad_r <= 3'h0;
		end else if (!prbs_chk || !locked_r) begin
			bad_r <= 3'h0;
		end else if (chk_miss) begin
			bad_r <= bad_r + 3'h1;
		end else if (lock_run) begin
			bad_r <= 3'h0;
		end
	end

	// Lock needs a run of good bits; lost on disable or too many misses
	always_ff @(posedge clock or negedge rst_n_r) begin
		if (!rst_n_r) begin
			locked_r <= 1'b0;
		end else if (!prbs_chk || lock_drop) begin
			locked_r <= 1'b0;
		end else if (lock_run) begin
			locked_r <= 1'b1;
		end
	end

	// Received history for the mixed check
	always_ff @(posedge clock or negedge rst_n_r) begin
		if (!rst_n_r) begin
			mix_hist_r <= 16'h0000;
		end else begin
			mix_hist_r <= {mix_hist_r[14:0], rx_bit};
		end
	end

	// Mixed error count; a miss in the read cycle survives the clear
	always_ff @(posedge clock or negedge rst_n_r) begin
		if (!rst_n_r) begin
			mix_err_r <= 16'h0000;
		end else if (rd_mix) begin
			mix_err_r <= {15'h0000, mix_miss};
		end else if (mix_miss && mix_err_r != wan_tp_pkg::count_max) begin
			mix_err_r <= mix_err_r + 16'h0001;
		end
	end

	logic [15:0] prbs_count;
	sat_counter u_prbs_cnt (
		.clock(clock),
		.rst_n(rst_n_r),
		.inc(prbs_inc),
		.read_clear(rd_cnt),
		.count(prbs_count)
	);

	// Read mux
	logic [15:0] rd_val;
	always_comb begin
		rd_val = 16'h0000;
		if (addr == wan_tp_pkg::addr_test_control) begin
			rd_val = ctrl_r;
		end else if (addr == wan_tp_pkg::addr_tx_ext_control) begin
			rd_val = {12'h000, width_r};
		end else if (addr == wan_tp_pkg::addr_test_status) begin
			rd_val[wan_tp_pkg::bit_prbs_supported_flag] = 1'b1;
		end else if (addr == wan_tp_pkg::addr_prbs_checker_status) begin
			rd_val[wan_tp_pkg::bit_prbs_error_nonzero] =
				(prbs_count != 16'h0000);
			rd_val[wan_tp_pkg::bit_prbs_checker_locked] = locked_r;
		end else if (addr == wan_tp_pkg::addr_prbs_error_count) begin
			rd_val = prbs_count;
		end else if (addr == wan_tp_pkg::addr_error_inject_control) begin
			rd_val = {15'h0000, inject_r};
		end else if (addr == wan_tp_pkg::addr_section_parity
			|| addr == wan_tp_pkg::addr_line_parity
			|| addr == wan_tp_pkg::addr_path_parity) begin
			rd_val = mix_err_r;
		end
	end

	always_ff @(posedge clock or negedge rst_n_r) begin
		if (!rst_n_r) begin
			rdata_r <= 16'h0000;
		end else begin
			rdata_r <= rd ? rd_val : 16'h0000;
		end
	end

	assign rdata = rdata_r;
	assign tx_bit = tx_r;
endmodule : wan_test_pattern_gen_check

// ---- rtl/wan_tp_pkg.sv ----
package wan_tp_pkg;
	localparam logic [3:0] addr_test_control = 4'h0;
	localparam logic [3:0] addr_tx_ext_control = 4'h1;
	localparam logic [3:0] addr_test_status = 4'h2;
	localparam logic [3:0] addr_prbs_checker_status = 4'h3;
	localparam logic [3:0] addr_prbs_error_count = 4'h4;
	localparam logic [3:0] addr_error_inject_control = 4'h5;
	localparam logic [3:0] addr_section_parity = 4'h6;
	localparam logic [3:0] addr_line_parity = 4'h7;
	localparam logic [3:0] addr_path_parity = 4'h8;
	// test_control_reg fields
	localparam int bit_square_wave_select = 0;
	localparam int bit_pattern_gen_enable = 1;
	localparam int bit_pattern_check_enable = 2;
	localparam int bit_prbs_gen_enable = 3;
	localparam int bit_prbs_check_enable = 4;
	// test_status_reg / prbs_checker_status_reg fields
	localparam int bit_prbs_supported_flag = 0;
	localparam int bit_prbs_error_nonzero = 0;
	localparam int bit_prbs_checker_locked = 1;
	localparam int bit_inject_bit_error = 0;
	localparam int square_width_bits = 4;
	localparam logic [3:0] square_width_reset = 4'h4;
	localparam int count_bits = 16;
	localparam logic [15:0] count_max = 16'hffff;
	localparam int prbs_len = 31;
	localparam int prbs_tap = 28;
	localparam logic [30:0] prbs_seed = 31'h7fffffff;
	localparam logic [4:0] lock_good_bits = 5'h1f;
	localparam logic [2:0] lock_bad_limit = 3'h3;
	localparam int mix_len = 16;
	localparam logic [15:0] mix_pattern = 16'hf0cc;
	localparam logic [1:0] pattern_square = 2'h0;
	localparam logic [1:0] pattern_mixed = 2'h1;
	localparam logic [1:0] pattern_prbs = 2'h2;
	localparam logic [1:0] pattern_idle = 2'h3;
endpackage : wan_tp_pkg
